// ### hpc_pkg.sv
// constants and types shared by the haptic playback control design
package hpc_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned PWM_HZ_X2     = 375_000;      // 187.5 kHz, doubled
  localparam int unsigned PWM_CYC       = (2 * CLK_HZ) / PWM_HZ_X2;
  localparam int unsigned WAKE_IDLE_US  = 750;          // 0.75 ms
  localparam int unsigned WAKE_STBY_US  = 150;          // 0.15 ms
  localparam int unsigned STEP_US       = 1000;         // memory time unit
  localparam int unsigned WAKE_IDLE_CYC = (CLK_HZ / 1_000_000) * WAKE_IDLE_US;
  localparam int unsigned WAKE_STBY_CYC = (CLK_HZ / 1_000_000) * WAKE_STBY_US;
  localparam int unsigned STEP_CYC      = (CLK_HZ / 1_000_000) * STEP_US;
  localparam logic [9:0]  FREQ_MIN_HZ   = 10'd25;
  localparam logic [9:0]  FREQ_MAX_HZ   = 10'd1000;
  localparam logic [7:0]  PH_K          = 8'(64'h1_0000_0000 / CLK_HZ);

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int unsigned WAVE_MEM_BYTES = 100;
  localparam int unsigned STREAM_DEPTH   = 2;
  localparam logic [4:0]  ADDR_BASE_RST  = 5'h0A;       // arbitrary value
  localparam logic [63:0] SINE_TAB       = 64'h328ED4FAFAD48E32;

  // ----------------------------------------
  // fault bit positions
  // ----------------------------------------
  localparam int unsigned F_IMP   = 0;
  localparam int unsigned F_BACKV = 1;
  localparam int unsigned F_RES   = 2;
  localparam int unsigned F_SHORT = 3;

  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_BUS      = 3'h1,
    MODE_PIN      = 3'h2,
    MODE_REG_MEM  = 3'h3,
    MODE_EDGE_MEM = 3'h4
  } hpc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WAKE  = 3'h1,
    ST_STBY  = 3'h2,
    ST_MEAS  = 3'h3,
    ST_DRIVE = 3'h4
  } hpc_state_t;

  typedef enum logic [1:0] {
    SHAPE_SINE   = 2'h0,
    SHAPE_SQUARE = 2'h1,
    SHAPE_CUSTOM = 2'h2
  } hpc_shape_t;

endpackage

// ### hpc_stream_if.sv
// stream carrier between the core and its word buffer
`timescale 1ns/100ps
interface hpc_stream_if #(
  parameter int unsigned W = 8
);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport buf_side (
    input  in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
  modport core_side (
    output in_valid, in_data, out_ready,
    input  in_ready, out_valid, out_data
  );
endinterface

// ### hpc_buf.sv
// small valid/ready word buffer for streamed drive levels
`timescale 1ns/100ps
module hpc_buf #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic          clk,
  input wire logic          rst_n,
  hpc_stream_if.buf_side    s
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          ready_q;
  logic          push;
  logic          pop;

  assign push        = s.in_valid && ready_q;
  assign pop         = (cnt_q != '0) && s.out_ready;
  assign s.in_ready  = ready_q;
  assign s.out_valid = (cnt_q != '0);
  assign s.out_data  = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // ----------------------------------------
  // occupancy and pointers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      ready_q <= 1'b0;
      wr_q    <= '0;
      rd_q    <= '0;
    end else begin
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != (AW+1)'(DEPTH));
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= s.in_data;
    end
  end

endmodule

// ### hpc_core.sv
// haptic playback control: wake, source select, memory playback, drive, faults
`timescale 1ns/100ps
module hpc_core #(
  parameter int unsigned WAKE_IDLE_CYC = hpc_pkg::WAKE_IDLE_CYC,
  parameter int unsigned WAKE_STBY_CYC = hpc_pkg::WAKE_STBY_CYC,
  parameter int unsigned STEP_CYC      = hpc_pkg::STEP_CYC,
  parameter int unsigned MEM_BYTES     = hpc_pkg::WAVE_MEM_BYTES,
  parameter logic [4:0]  ADDR_BASE     = hpc_pkg::ADDR_BASE_RST
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        trigger_input_pin,
  input  wire logic        bus_activity,
  input  wire logic [1:0]  edge_sel,
  input  wire logic        parity_en,
  input  wire logic [2:0]  op_mode,
  input  wire logic        standby_en,
  input  wire logic        embedded_en,
  input  wire logic        sequence_launch,
  input  wire logic [6:0]  seq_a_start,
  input  wire logic [6:0]  seq_b_start,
  input  wire logic        stream_valid,
  input  wire logic [7:0]  streamed_drive_level,
  output logic             stream_ready,
  input  wire logic        mem_wr,
  input  wire logic [6:0]  mem_waddr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [9:0]  drive_freq_hz,
  input  wire logic [1:0]  wave_shape,
  input  wire logic [63:0] custom_shape,
  input  wire logic        open_loop,
  input  wire logic [3:0]  loop_feat_en,
  input  wire logic [9:0]  res_freq_hz,
  input  wire logic [7:0]  imp_meas,
  input  wire logic [7:0]  supply_meas,
  input  wire logic [3:0]  fault_in,
  input  wire logic        fault_clear,
  input  wire logic [1:0]  addr_strap,
  output logic             drive_out_pos,
  output logic             drive_out_neg,
  output logic             drive_oe,
  output logic             fault_alert_line_n,
  output logic [3:0]       fault_flags,
  output logic [7:0]       impedance,
  output logic [7:0]       supply_level,
  output logic [6:0]       slave_addr,
  output logic [3:0]       loop_feat_act,
  output logic [2:0]       play_state
);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  logic [7:0] pin_raw;
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  logic [7:0] pin_q;

  assign pin_raw = {trigger_input_pin, bus_activity, fault_in, addr_strap};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= 8'h00;
      s2_q  <= 8'h00;
      s3_q  <= 8'h00;
      pin_q <= 8'h00;
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end

  // ----------------------------------------
  // trigger edges and event parity
  // ----------------------------------------
  hpc_pkg::hpc_mode_t  mode;
  hpc_pkg::hpc_state_t st_q;
  logic trig_d_q;
  logic bus_d_q;
  logic parity_q;
  logic edge_evt;
  logic bus_wake;

  assign mode     = hpc_pkg::hpc_mode_t'(op_mode);
  assign edge_evt = (mode == hpc_pkg::MODE_EDGE_MEM)
                  && ((pin_q[7] && !trig_d_q && edge_sel[0])
                  ||  (!pin_q[7] && trig_d_q && edge_sel[1]));
  assign bus_wake = pin_q[6] && !bus_d_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_d_q <= 1'b0;
      bus_d_q  <= 1'b0;
      parity_q <= 1'b0;
    end else begin
      trig_d_q <= pin_q[7];
      bus_d_q  <= pin_q[6];
      if (edge_evt) begin
        parity_q <= !parity_q;
      end
    end
  end

  // ----------------------------------------
  // faults
  // ----------------------------------------
  logic [3:0] fault_act;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic       fault_now;
  logic       allow;

  assign fault_act = pin_q[5:2] & {1'b1, !open_loop, !open_loop, 1'b1};
  assign fault_now = |fault_act;
  assign allow     = embedded_en || (flags_q == 4'h0);

  always_comb begin
    flags_d = flags_q;
    if (fault_clear || (embedded_en && st_q == hpc_pkg::ST_MEAS)) begin
      flags_d = 4'h0;
    end
    flags_d = flags_d | fault_act;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q            <= 4'h0;
      fault_alert_line_n <= 1'b1;
      drive_oe           <= 1'b1;
    end else begin
      flags_q            <= flags_d;
      fault_alert_line_n <= !(|flags_d);
      drive_oe           <= !flags_d[hpc_pkg::F_SHORT];
    end
  end

  // ----------------------------------------
  // playback requests
  // ----------------------------------------
  logic strm_mode;
  logic mem_mode;
  logic launch;
  logic pend_q;
  logic pend_b_q;
  logic go;

  assign strm_mode = (mode == hpc_pkg::MODE_BUS) || (mode == hpc_pkg::MODE_PIN);
  assign mem_mode  = (mode == hpc_pkg::MODE_REG_MEM) || (mode == hpc_pkg::MODE_EDGE_MEM);
  assign launch    = (sequence_launch && mem_mode) || edge_evt;
  assign go        = allow && (pend_q || strm_mode);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q   <= 1'b0;
      pend_b_q <= 1'b0;
    end else begin
      if (launch && allow) begin
        pend_q   <= 1'b1;
        pend_b_q <= edge_evt && parity_en && parity_q;
      end else if (st_q == hpc_pkg::ST_MEAS) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // system state machine
  // ----------------------------------------
  logic [15:0] wait_q;
  logic        run_mem_q;
  logic [2:0]  run_mode_q;
  logic        mem_done;
  logic        end_play;

  assign end_play   = run_mem_q ? mem_done : (op_mode != run_mode_q);
  assign play_state = st_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= hpc_pkg::ST_IDLE;
      wait_q     <= 16'h0000;
      run_mem_q  <= 1'b0;
      run_mode_q <= 3'h0;
    end else begin
      case (st_q)
        hpc_pkg::ST_IDLE: begin
          if (go || bus_wake) begin
            wait_q <= 16'(WAKE_IDLE_CYC - 1);
            st_q   <= hpc_pkg::ST_WAKE;
          end
        end
        hpc_pkg::ST_STBY: begin
          if (go) begin
            wait_q <= 16'(WAKE_STBY_CYC - 1);
            st_q   <= hpc_pkg::ST_WAKE;
          end
        end
        hpc_pkg::ST_WAKE: begin
          if (wait_q != 16'h0000) begin
            wait_q <= wait_q - 16'h0001;
          end else if (go) begin
            st_q <= hpc_pkg::ST_MEAS;
          end else begin
            st_q <= standby_en ? hpc_pkg::ST_STBY : hpc_pkg::ST_IDLE;
          end
        end
        hpc_pkg::ST_MEAS: begin
          run_mem_q  <= pend_q && mem_mode;
          run_mode_q <= op_mode;
          st_q       <= fault_now ? hpc_pkg::ST_IDLE : hpc_pkg::ST_DRIVE;
        end
        hpc_pkg::ST_DRIVE: begin
          if (fault_now) begin
            st_q <= hpc_pkg::ST_IDLE;
          end else if (end_play) begin
            st_q <= standby_en ? hpc_pkg::ST_STBY : hpc_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= hpc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // sequence start: impedance, shape; every cycle: supply, address, loop features
  // ----------------------------------------
  hpc_pkg::hpc_shape_t shape_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      impedance     <= 8'h00;
      shape_q       <= hpc_pkg::SHAPE_SINE;
      supply_level  <= 8'h00;
      slave_addr    <= 7'h00;
      loop_feat_act <= 4'h0;
    end else begin
      if (st_q == hpc_pkg::ST_MEAS) begin
        impedance <= imp_meas;
        shape_q   <= hpc_pkg::hpc_shape_t'(wave_shape);
      end
      supply_level  <= supply_meas;
      slave_addr    <= {ADDR_BASE, pin_q[1:0]};
      loop_feat_act <= open_loop ? 4'h0 : loop_feat_en;
    end
  end

  // ----------------------------------------
  // waveform memory and its playback
  // ----------------------------------------
  logic [7:0]  wmem_q [MEM_BYTES];
  logic [6:0]  ptr_q;
  logic [15:0] step_q;
  logic [3:0]  dur_q;
  logic [7:0]  amp_q;
  logic [9:0]  mfreq_q;
  logic [7:0]  cur;
  logic        in_range;

  assign in_range = (32'(ptr_q) < MEM_BYTES);
  assign cur      = in_range ? wmem_q[ptr_q] : 8'h00;
  assign mem_done = (step_q == 16'h0000) && (dur_q == 4'h0) && (cur == 8'h00);

  always_ff @(posedge clk) begin
    if (mem_wr && (32'(mem_waddr) < MEM_BYTES)) begin
      wmem_q[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q   <= 7'h00;
      step_q  <= 16'h0000;
      dur_q   <= 4'h0;
      amp_q   <= 8'h00;
      mfreq_q <= 10'h000;
    end else if (st_q == hpc_pkg::ST_MEAS) begin
      ptr_q   <= pend_b_q ? seq_b_start : seq_a_start;
      step_q  <= 16'h0000;
      dur_q   <= 4'h0;
      amp_q   <= 8'h00;
      mfreq_q <= 10'h000;
    end else if (st_q == hpc_pkg::ST_DRIVE && run_mem_q) begin
      if (step_q != 16'h0000) begin
        step_q <= step_q - 16'h0001;
      end else if (dur_q != 4'h0) begin
        dur_q  <= dur_q - 4'h1;
        step_q <= 16'(STEP_CYC - 1);
      end else if (!mem_done) begin
        ptr_q <= ptr_q + 7'h01;
        if (cur[7]) begin
          mfreq_q <= {cur[6:0], 3'h0};
        end else begin
          amp_q <= {cur[6:4], cur[6:4], cur[6:5]};
          dur_q <= cur[3:0];
        end
      end
    end
  end

  // ----------------------------------------
  // envelope sources
  // ----------------------------------------
  hpc_stream_if #(.W(8)) strm ();

  hpc_buf #(
    .W     (8),
    .DEPTH (hpc_pkg::STREAM_DEPTH)
  ) u_buf (
    .clk   (clk),
    .rst_n (rst_n),
    .s     (strm)
  );

  logic [15:0] filt_q;
  logic [7:0]  strm_q;
  logic [7:0]  pwm_q;
  logic        pwm_wrap;

  assign pwm_wrap       = (pwm_q == 8'(hpc_pkg::PWM_CYC - 1));
  assign strm.in_valid  = stream_valid;
  assign strm.in_data   = streamed_drive_level;
  assign strm.out_ready = (mode == hpc_pkg::MODE_BUS) && pwm_wrap;
  assign stream_ready   = strm.in_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= 16'h0000;
      strm_q <= 8'h00;
    end else begin
      if (pin_q[7]) begin
        filt_q <= filt_q + ((~filt_q) >> 6);
      end else begin
        filt_q <= filt_q - (filt_q >> 6);
      end
      if (strm.out_ready && strm.out_valid) begin
        strm_q <= strm.out_data;
      end
    end
  end

  // ----------------------------------------
  // drive frequency and phase
  // ----------------------------------------
  logic [9:0]  f_sel;
  logic [9:0]  f_drv;
  logic [31:0] ph_q;

  always_comb begin
    if (!open_loop && loop_feat_en[0]) begin
      f_sel = res_freq_hz;
    end else if (run_mem_q && mfreq_q != 10'h000) begin
      f_sel = mfreq_q;
    end else begin
      f_sel = drive_freq_hz;
    end
    f_drv = f_sel;
    if (f_sel < hpc_pkg::FREQ_MIN_HZ) begin
      f_drv = hpc_pkg::FREQ_MIN_HZ;
    end else if (f_sel > hpc_pkg::FREQ_MAX_HZ) begin
      f_drv = hpc_pkg::FREQ_MAX_HZ;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 32'h0000_0000;
    end else if (st_q == hpc_pkg::ST_DRIVE) begin
      ph_q <= ph_q + 32'(f_drv * hpc_pkg::PH_K);
    end else begin
      ph_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // shaping, supply limit and bridge switching
  // ----------------------------------------
  logic [7:0]  src;
  logic [7:0]  lvl;
  logic [7:0]  shp;
  logic [15:0] prod;
  logic [7:0]  mag;
  logic [15:0] duty_p;
  logic [7:0]  duty_q;
  logic        pol_q;

  always_comb begin
    case (run_mode_q)
      3'h1:    src = strm_q;
      3'h2:    src = filt_q[15:8];
      default: src = amp_q;
    endcase
    lvl = (src > supply_meas) ? supply_meas : src;
    if (shape_q == hpc_pkg::SHAPE_CUSTOM) begin
      shp = custom_shape[ph_q[30:28]*8 +: 8];
    end else begin
      shp = hpc_pkg::SINE_TAB[ph_q[30:28]*8 +: 8];
    end
    prod   = lvl * shp;
    mag    = (shape_q == hpc_pkg::SHAPE_SQUARE) ? lvl : prod[15:8];
    duty_p = mag * 8'(hpc_pkg::PWM_CYC);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_q         <= 8'h00;
      duty_q        <= 8'h00;
      pol_q         <= 1'b0;
      drive_out_pos <= 1'b0;
      drive_out_neg <= 1'b0;
    end else begin
      pwm_q <= pwm_wrap ? 8'h00 : pwm_q + 8'h01;
      if (pwm_wrap) begin
        duty_q <= duty_p[15:8];
        pol_q  <= ph_q[31];
      end
      if (st_q == hpc_pkg::ST_DRIVE && !fault_now) begin
        drive_out_pos <= !pol_q && (pwm_q < duty_q);
        drive_out_neg <= pol_q && (pwm_q < duty_q);
      end else begin
        drive_out_pos <= 1'b0;
        drive_out_neg <= 1'b0;
      end
    end
  end

  assign fault_flags = flags_q;

endmodule

// ### hpc_core_asserts.sv
// concurrent checks on the haptic playback control top
`timescale 1ns/100ps
module hpc_core_asserts #(
  parameter int unsigned WAKE_IDLE_CYC = 30,
  parameter int unsigned WAKE_STBY_CYC = 6
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       open_loop,
  input wire logic [3:0] loop_feat_en,
  input wire logic [7:0] imp_meas,
  input wire logic [7:0] supply_meas,
  input wire logic [3:0] fault_flags,
  input wire logic       fault_alert_line_n,
  input wire logic       drive_oe,
  input wire logic       drive_out_pos,
  input wire logic       drive_out_neg,
  input wire logic [7:0] impedance,
  input wire logic [7:0] supply_level,
  input wire logic [3:0] loop_feat_act,
  input wire logic [2:0] play_state
);
  localparam int IDLE_LIM = WAKE_IDLE_CYC + 1;
  localparam int STBY_LIM = WAKE_STBY_CYC + 1;
  logic [15:0] wake_cnt_q;
  logic        from_stby_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----
  // wake length and its origin
  // ----
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_cnt_q <= 16'h0000;
    end else begin
      wake_cnt_q <= (play_state == hpc_pkg::ST_WAKE) ? wake_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      from_stby_q <= 1'b0;
    end else if (play_state != hpc_pkg::ST_WAKE) begin
      from_stby_q <= (play_state == hpc_pkg::ST_STBY);
    end
  end

  // ----
  // properties
  // ----
  sequence s_wake_end;
    $fell(play_state == hpc_pkg::ST_WAKE);
  endsequence
  sequence s_measure;
    play_state == hpc_pkg::ST_MEAS;
  endsequence
  sequence s_fault_new;
    $rose(|fault_flags);
  endsequence

  a_alert_follows_flags: assert property ($past(arst_n) |-> fault_alert_line_n == !(|fault_flags))
    else $error("alert line does not follow the fault flags");
  a_short_bridge_off: assert property (fault_flags[3] |-> !drive_oe)
    else $error("bridge still driven with a short flagged");
  a_fault_to_idle: assert property (s_fault_new |=> play_state == hpc_pkg::ST_IDLE)
    else $error("fault did not force the idle state");
  a_fault_drive_off: assert property (s_fault_new |=> !drive_out_pos && !drive_out_neg)
    else $error("bridge still switching after a fault");
  a_loop_feat_mask: assert property ($past(arst_n, 4) |->
    loop_feat_act == ($past(loop_feat_en) & {4{!$past(open_loop)}}))
    else $error("loop features not masked by open loop");
  a_supply_report: assert property ($past(arst_n, 4) |-> supply_level == $past(supply_meas))
    else $error("supply level not reported");
  a_meas_capture: assert property (s_measure |=> impedance == $past(imp_meas))
    else $error("impedance not captured at sequence start");
  a_wake_latency: assert property (s_wake_end |-> int'(wake_cnt_q) <= (from_stby_q ? STBY_LIM : IDLE_LIM))
    else $error("wake took too long");
endmodule

bind hpc_core hpc_core_asserts #(
  .WAKE_IDLE_CYC(WAKE_IDLE_CYC),
  .WAKE_STBY_CYC(WAKE_STBY_CYC)
) u_asserts (
  .clk(clk), .arst_n(arst_n), .open_loop(open_loop), .loop_feat_en(loop_feat_en),
  .imp_meas(imp_meas), .supply_meas(supply_meas), .fault_flags(fault_flags),
  .fault_alert_line_n(fault_alert_line_n), .drive_oe(drive_oe), .drive_out_pos(drive_out_pos),
  .drive_out_neg(drive_out_neg), .impedance(impedance), .supply_level(supply_level),
  .loop_feat_act(loop_feat_act), .play_state(play_state)
);

// ### hpc_host_model.sv
// host model offering streamed drive levels on valid and ready
`timescale 1ns/100ps
module hpc_host_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic slow,
  input  wire logic stream_ready,
  output logic      stream_valid,
  output logic [7:0] streamed_drive_level,
  output int        sent
);
  logic tick;

  initial begin
    stream_valid = 1'b0;
    streamed_drive_level = 8'h5A;
    sent = 0;
    tick = 1'b0;
  end
  // word held until taken; idle data keeps changing
  always @(posedge clk) begin
    tick <= ~tick;
    if (stream_valid && stream_ready) begin
      sent <= sent + 1;
    end
    if (!stream_valid || stream_ready) begin
      stream_valid <= go && (!slow || tick);
      streamed_drive_level <= go ? 8'h40 + 8'(sent + 1) : ~streamed_drive_level;
    end
  end
endmodule

// ### testbench.sv
// self-checking bench for the haptic playback control top
`timescale 1ns/100ps
module testbench;
  // ----
  // signals
  // ----
  logic        clk, arst_n, trigger_input_pin, bus_activity, parity_en, standby_en, embedded_en;
  logic        sequence_launch, stream_valid, stream_ready, mem_wr, open_loop, fault_clear;
  logic        drive_out_pos, drive_out_neg, drive_oe, fault_alert_line_n, go, slow;
  logic [1:0]  edge_sel, wave_shape, addr_strap;
  logic [2:0]  op_mode, play_state;
  logic [3:0]  loop_feat_en, fault_in, fault_flags, loop_feat_act;
  logic [6:0]  seq_a_start, seq_b_start, mem_waddr, slave_addr;
  logic [7:0]  streamed_drive_level, mem_wdata, imp_meas, supply_meas, impedance, supply_level;
  logic [9:0]  drive_freq_hz, res_freq_hz;
  logic [31:0] rnd;
  logic [63:0] custom_shape;
  logic [8:0]  notes[$];
  logic [6:0]  wa[6] = '{7'h00, 7'h01, 7'h02, 7'h0A, 7'h0B, 7'h64};
  logic [7:0]  wd[6] = '{8'h8A, 8'h7F, 8'h00, 8'h72, 8'h00, 8'h7F};
  int          error_cnt, tests_run, sent, ev;

  hpc_core #(.WAKE_IDLE_CYC(30), .WAKE_STBY_CYC(6), .STEP_CYC(8)) dut (.*);
  hpc_host_model host (.*);

  always #12.5 clk = ~clk;

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // note playback length class and impedance
  task automatic arm(input logic lng);
    imp_meas <= rnd[7:0];
    notes.push_back({lng, rnd[7:0]});
  endtask
  task automatic launch(input logic lng);
    arm(lng);
    sequence_launch <= 1'b1;
    cyc(1);
    sequence_launch <= 1'b0;
    cyc(1);
  endtask
  task automatic settle();
    int n;
    n = 0;
    while ((notes.size() != 0 || play_state inside {3'h1, 3'h3, 3'h4}) && n < 3000) begin
      cyc(1);
      n++;
    end
    chk("settle", 9'(n == 3000), 9'h000);
  endtask
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (play_state !== s && n < 500) begin
      cyc(1);
      n++;
    end
    chk("state", 9'(play_state), 9'(s));
  endtask
  task automatic pin_edge(input logic lvl, input logic qual);
    if (qual) begin
      ev++;
      arm(ev[0] | !parity_en);
    end
    trigger_input_pin <= lvl;
    cyc(40);
    if (qual) settle();
    else chk("state", 9'(play_state), 9'(hpc_pkg::ST_IDLE));
  endtask

  // ----
  // random inputs and result watcher
  // ----
  always @(posedge clk) begin
    rnd <= lfsr(rnd);
    supply_meas <= rnd[15:8];
    loop_feat_en <= rnd[19:16];
    wave_shape <= rnd[21:20] % 2'h3;
    custom_shape <= {2{rnd}};
  end
  initial begin
    int len;
    logic [7:0] imp_seen;
    len = 0;
    imp_seen = 8'h00;
    forever begin
      @(posedge clk);
      if (play_state === hpc_pkg::ST_DRIVE) begin
        if (len == 0) imp_seen = impedance;
        len++;
      end else if (len != 0) begin
        chk("playback", {len > 60, imp_seen}, notes.size() ? notes.pop_front() : 9'h1FF);
        len = 0;
      end
    end
  end
  initial begin
    cyc(40000);
    error_cnt++;
    tally_and_finish();
  end

  // ----
  // main sequence
  // ----
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {trigger_input_pin, bus_activity, sequence_launch, mem_wr, open_loop, fault_clear} = '0;
    {go, slow, standby_en, embedded_en, edge_sel, parity_en, op_mode} = 10'h00B;
    {seq_a_start, seq_b_start, mem_waddr, mem_wdata} = {7'h00, 7'h0A, 7'h00, 8'h00};
    {drive_freq_hz, res_freq_hz, fault_in, addr_strap} = {10'h0C8, 10'h096, 4'h0, 2'h0};
    {imp_meas, supply_meas, loop_feat_en, wave_shape, custom_shape} = '0;
    rnd = 32'h1A4E;
    ev = 0;
    cyc(16);
    arst_n <= 1'b1;
    cyc(10);
    chk("alert", 9'({fault_alert_line_n, fault_flags}), 9'h010);
    for (int s = 0; s < 4; s++) begin
      addr_strap <= 2'(s);
      cyc(6);
      chk("address", 9'(slave_addr), 9'({hpc_pkg::ADDR_BASE_RST, 2'(s)}));
    end
    foreach (wa[i]) begin
      mem_wr <= 1'b1;
      mem_waddr <= wa[i];
      mem_wdata <= wd[i];
      cyc(1);
    end
    mem_wr <= 1'b0;
    $display("test setup finished");
    op_mode <= 3'h3;
    standby_en <= 1'b1;
    cyc(2);
    launch(1'b1);
    wait_st(hpc_pkg::ST_DRIVE);
    launch(1'b1);
    settle();
    chk("state", 9'(play_state), 9'(hpc_pkg::ST_STBY));
    standby_en <= 1'b0;
    launch(1'b1);
    settle();
    chk("state", 9'(play_state), 9'(hpc_pkg::ST_IDLE));
    bus_activity <= 1'b1;
    cyc(6);
    bus_activity <= 1'b0;
    chk("state", 9'(play_state), 9'(hpc_pkg::ST_WAKE));
    cyc(40);
    chk("state", 9'(play_state), 9'(hpc_pkg::ST_IDLE));
    $display("test launch finished");
    op_mode <= 3'h4;
    for (int s = 1; s < 4; s++) begin
      edge_sel <= 2'(s);
      pin_edge(1'b1, s[0]);
      pin_edge(1'b0, s[1]);
    end
    parity_en <= 1'b0;
    edge_sel <= 2'h1;
    pin_edge(1'b1, 1'b1);
    pin_edge(1'b0, 1'b0);
    $display("test edges finished");
    op_mode <= 3'h3;
    launch(1'b0);
    wait_st(hpc_pkg::ST_DRIVE);
    fault_in <= 4'h8;
    cyc(8);
    chk("bridge", 9'({drive_oe, fault_alert_line_n, play_state}), 9'h000);
    fault_in <= 4'h0;
    settle();
    sequence_launch <= 1'b1;
    cyc(1);
    sequence_launch <= 1'b0;
    cyc(50);
    chk("state", 9'(play_state), 9'(hpc_pkg::ST_IDLE));
    embedded_en <= 1'b1;
    launch(1'b1);
    settle();
    embedded_en <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      open_loop <= (b == 1);
      fault_in <= 4'(1 << b);
      cyc(10);
      chk("flags", 9'(fault_flags), (b == 1) ? 9'h000 : 9'(1 << b));
      fault_in <= 4'h0;
      cyc(5);
      fault_clear <= 1'b1;
      cyc(1);
      fault_clear <= 1'b0;
      cyc(1);
    end
    $display("test faults finished");
    arm(1'b1);
    go <= 1'b1;
    slow <= 1'b1;
    cyc(8);
    chk("ready", 9'(stream_ready), 9'h000);
    op_mode <= 3'h1;
    cyc(700);
    op_mode <= 3'h0;
    go <= 1'b0;
    settle();
    chk("words", 9'(sent > 3), 9'h001);
    arm(1'b1);
    op_mode <= 3'h2;
    repeat (400) begin
      trigger_input_pin <= rnd[3];
      cyc(1);
    end
    op_mode <= 3'h0;
    settle();
    $display("test streams finished");
    chk("notes left", 9'(notes.size()), 9'h000);
    tally_and_finish();
  end
endmodule
